/* hw/skto_pkg.sv */
package skto_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] SKTO_IDX_RTC = 8'hDA;
  localparam logic [7:0] SKTO_IDX_KEY = 8'hDB;
  localparam logic [7:0] SKTO_IDX_SIG = 8'hE0;
  localparam logic [7:0] SKTO_IDX_RAIL = 8'hE1;
  localparam logic [7:0] SKTO_IDX_CHG = 8'hE2;
  localparam logic [7:0] SKTO_IDX_FEN = 8'hE6;
  localparam logic [7:0] SKTO_IDX_NONE = 8'h00;
  localparam logic [2:0] SKTO_HSIZE_WORD = 3'h2;

  // ==========================================================
  // key, reset values and field layouts
  localparam logic [15:0] SKTO_UNLOCK = 16'h0013;
  localparam logic [15:0] SKTO_KEY_RST = 16'h0000;
  localparam logic [15:0] SKTO_OVR_RST = 16'h0000;
  localparam logic [15:0] SKTO_RTC_RST = 16'h9000;
  localparam logic [15:0] SKTO_RTC_WMASK = 16'hB3FF;
  localparam int SKTO_RTC_TICK_ENA = 15;
  localparam int SKTO_RTC_TICK_STS = 14;
  localparam int SKTO_RTC_CLKSRC = 13;
  localparam int SKTO_RTC_OSC_ENA = 12;
  localparam logic [15:0] SKTO_SIG_WMASK = 16'h0FCF;
  localparam logic [15:0] SKTO_SIG_CMP = 16'h0C8F;
  localparam logic [15:0] SKTO_RAIL_CMP = 16'h8F3F;
  localparam logic [15:0] SKTO_CHG_CMP = 16'hC807;
  localparam int SKTO_LOCK_FORCE_BIT = 9;
  localparam int SKTO_TICK_FORCE_BIT = 8;
  localparam int SKTO_ALARM_FORCE_BIT = 6;

  // ==========================================================
  // timing: forced debounce tick rate
  localparam int SKTO_CLK_HZ = 250000000;
  localparam int SKTO_FAST_TICK_HZ = 16000;
  localparam int SKTO_FAST_TICK_DIV = SKTO_CLK_HZ / SKTO_FAST_TICK_HZ;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [15:0] sig;
    logic [15:0] rail;
    logic [15:0] chg;
  } skto_ana_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] wdata;
  } skto_req_t;

  typedef enum logic {SKTO_AHB_IDLE, SKTO_AHB_RD} skto_ahb_st_t;

  typedef struct packed {
    skto_ahb_st_t st;
    logic wr_pend;
    logic [7:0] idx;
    logic hready;
    logic [31:0] hrdata;
  } skto_ahb_state_t;

  typedef struct packed {
    logic [15:0] key;
    logic [15:0] rtc;
    logic [15:0] sig;
    logic [15:0] rail;
    logic [15:0] chg;
    logic force_en;
    skto_ana_t deb;
    logic lock_out;
    logic alarm_out;
    logic tick_out;
  } skto_top_state_t;

endpackage : skto_pkg

/* hw/skto_tick_gen.sv */
`timescale 1ns/1ps
module skto_tick_gen #(
  parameter int DIV = skto_pkg::SKTO_FAST_TICK_DIV
) (
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);
  import skto_pkg::*;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } skto_tick_state_t;

  skto_tick_state_t s_q;
  skto_tick_state_t s_d;

  // free-running divider, one-cycle pulse per wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : skto_tick_gen

/* hw/skto_ahb_front.sv */
`timescale 1ns/1ps
module skto_ahb_front (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] rd_data,
  output skto_pkg::skto_req_t req,
  output logic hreadyout,
  output logic [31:0] hrdata
);
  import skto_pkg::*;

  skto_ahb_state_t s_q;
  skto_ahb_state_t s_d;
  logic take;
  logic hit;

  // only whole aligned words inside the 1 KiB window decode
  assign take = hsel && hready && htrans[1];
  assign hit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && (hsize == SKTO_HSIZE_WORD);

  // reads take one wait state so hrdata comes from a flop
  always_comb begin
    s_d = s_q;
    s_d.wr_pend = 1'b0;
    case (s_q.st)
      SKTO_AHB_IDLE: begin
        if (take) begin
          s_d.idx = hit ? haddr[9:2] : SKTO_IDX_NONE;
          if (hwrite) begin
            s_d.wr_pend = 1'b1;
          end else begin
            s_d.st = SKTO_AHB_RD;
            s_d.hready = 1'b0;
          end
        end
      end
      SKTO_AHB_RD: begin
        s_d.hrdata = rd_data;
        s_d.hready = 1'b1;
        s_d.st = SKTO_AHB_IDLE;
      end
      default: begin
        s_d.st = SKTO_AHB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: SKTO_AHB_IDLE, wr_pend: 1'b0, idx: SKTO_IDX_NONE, hready: 1'b1,
               hrdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // write data is taken straight from the data phase
  assign req.wr = s_q.wr_pend;
  assign req.rd = (s_q.st == SKTO_AHB_RD);
  assign req.idx = s_q.idx;
  assign req.wdata = hwdata;
  assign hreadyout = s_q.hready;
  assign hrdata = s_q.hrdata;

endmodule : skto_ahb_front

/* hw/skto_regs.sv */
// Summary of operation
// - protected writes allowed only while key holds 0013h; key resets to zero.
// - timekeeping tick, source, oscillator and trim fields need the key unlocked.
// - comparator override bits read back the live raw analogue value.
// - with global force enable set, written override bits feed the debounce logic.
// - signal-override bit 9 forces the loop lock indication true.
// - signal-override bit 8 replaces every debounce tick with the 16 kHz tick.
// - signal-override bit 6 forces the alarm high.
// - power state machine clears switch, regulator and converter status bits.
`timescale 1ns/1ps
module skto_regs #(
  parameter int FAST_TICK_DIV = skto_pkg::SKTO_FAST_TICK_DIV
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input skto_pkg::skto_ana_t ana_raw,
  input wire logic loop_lock_raw,
  input wire logic alarm_raw,
  input wire logic deb_tick_raw,
  input wire logic psm_clear,
  output skto_pkg::skto_ana_t deb_in,
  output logic loop_lock,
  output logic alarm,
  output logic deb_tick,
  output logic rtc_tick_ena,
  output logic rtc_clksrc,
  output logic osc_ena,
  output logic [9:0] rtc_trim
);
  import skto_pkg::*;

  // ==========================================================
  // functions shared by readback and debounce feed

  // comparator bits show the raw level, control bits the stored value
  function automatic logic [15:0] readback(input logic [15:0] raw, input logic [15:0] stored,
                                           input logic [15:0] cmp, input logic [15:0] wmask);
    return (raw & cmp) | (stored & wmask & ~cmp);
  endfunction : readback

  // debounce input: software value when forcing, else the comparator
  function automatic logic [15:0] feed(input logic [15:0] raw, input logic [15:0] stored,
                                       input logic [15:0] cmp, input logic en);
    return en ? (stored & cmp) : (raw & cmp);
  endfunction : feed

  // ==========================================================
  // bus front end and forced tick source

  skto_req_t req;
  logic [31:0] rd_data;
  logic fast_tick;
  logic hready_q;
  logic [31:0] hrdata_q;

  skto_ahb_front u_front (
    .mclk(mclk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .rd_data(rd_data),
    .req(req),
    .hreadyout(hready_q),
    .hrdata(hrdata_q)
  );

  skto_tick_gen #(
    .DIV(FAST_TICK_DIV)
  ) u_fast_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(fast_tick)
  );

  // ==========================================================
  // register state

  skto_top_state_t s_q;
  skto_top_state_t s_d;
  logic unlocked;
  logic [15:0] wd16;

  assign unlocked = (s_q.key == SKTO_UNLOCK);
  assign wd16 = req.wdata[15:0];

  // read mux; unmapped indices read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (req.idx == SKTO_IDX_RTC) begin
      rd_data[15:0] = s_q.rtc;
      rd_data[SKTO_RTC_TICK_STS] = s_q.rtc[SKTO_RTC_TICK_ENA];
    end else if (req.idx == SKTO_IDX_KEY) begin
      rd_data[15:0] = s_q.key;
    end else if (req.idx == SKTO_IDX_SIG) begin
      rd_data[15:0] = readback(ana_raw.sig, s_q.sig, SKTO_SIG_CMP, SKTO_SIG_WMASK);
    end else if (req.idx == SKTO_IDX_RAIL) begin
      rd_data[15:0] = readback(ana_raw.rail, s_q.rail, SKTO_RAIL_CMP, SKTO_RAIL_CMP);
    end else if (req.idx == SKTO_IDX_CHG) begin
      rd_data[15:0] = readback(ana_raw.chg, s_q.chg, SKTO_CHG_CMP, SKTO_CHG_CMP);
    end else if (req.idx == SKTO_IDX_FEN) begin
      rd_data[0] = s_q.force_en;
    end
  end

  // writes, state machine clears and the registered outputs
  always_comb begin
    s_d = s_q;
    if (req.wr) begin
      if (req.idx == SKTO_IDX_KEY) begin
        s_d.key = wd16;
      end else if (req.idx == SKTO_IDX_RTC && unlocked) begin
        s_d.rtc = wd16 & SKTO_RTC_WMASK;
      end else if (req.idx == SKTO_IDX_SIG) begin
        s_d.sig = wd16 & SKTO_SIG_WMASK;
      end else if (req.idx == SKTO_IDX_RAIL) begin
        s_d.rail = wd16 & SKTO_RAIL_CMP;
      end else if (req.idx == SKTO_IDX_CHG) begin
        s_d.chg = wd16 & SKTO_CHG_CMP;
      end else if (req.idx == SKTO_IDX_FEN) begin
        s_d.force_en = req.wdata[0];
      end
    end
    // the state machine clear beats a software write in the same cycle
    if (psm_clear) begin
      s_d.key = SKTO_KEY_RST;
      s_d.rtc = SKTO_RTC_RST;
      s_d.rail = SKTO_OVR_RST;
    end
    // outputs register one cycle after their sources, keeping the debounce, lock, tick and alarm outputs on flops
    s_d.deb.sig = feed(ana_raw.sig, s_q.sig, SKTO_SIG_CMP, s_q.force_en);
    s_d.deb.rail = feed(ana_raw.rail, s_q.rail, SKTO_RAIL_CMP, s_q.force_en);
    s_d.deb.chg = feed(ana_raw.chg, s_q.chg, SKTO_CHG_CMP, s_q.force_en);
    s_d.lock_out = s_q.sig[SKTO_LOCK_FORCE_BIT] | loop_lock_raw;
    s_d.tick_out = s_q.sig[SKTO_TICK_FORCE_BIT] ? fast_tick : deb_tick_raw;
    s_d.alarm_out = s_q.sig[SKTO_ALARM_FORCE_BIT] | alarm_raw;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{key: SKTO_KEY_RST, rtc: SKTO_RTC_RST, sig: SKTO_OVR_RST, rail: SKTO_OVR_RST,
               chg: SKTO_OVR_RST, force_en: 1'b0, deb: '0, lock_out: 1'b0,
               alarm_out: 1'b0, tick_out: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // output wiring, every one from a flop except the constant hresp

  // the slave never errors, so the response is a constant okay
  assign hresp = 1'b0;
  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign deb_in = s_q.deb;
  assign loop_lock = s_q.lock_out;
  assign alarm = s_q.alarm_out;
  assign deb_tick = s_q.tick_out;
  assign rtc_tick_ena = s_q.rtc[SKTO_RTC_TICK_ENA];
  assign rtc_clksrc = s_q.rtc[SKTO_RTC_CLKSRC];
  assign osc_ena = s_q.rtc[SKTO_RTC_OSC_ENA];
  assign rtc_trim = s_q.rtc[9:0];

  // ==========================================================
  // assertions

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // key clear by the state machine lands on the next edge
  a_key_psm_clear: assert property (psm_clear |=> s_q.key == 16'h0000)
    else $error("key not cleared by state machine");

  // locked key keeps timekeeping fields frozen through a write
  a_locked_rtc_hold: assert property (
    req.wr && req.idx == SKTO_IDX_RTC && !unlocked && !psm_clear |=> $stable(s_q.rtc))
    else $error("protected field changed while locked");

  // unlocked write stores exactly the writable bits
  a_unlocked_rtc_write: assert property (
    req.wr && req.idx == SKTO_IDX_RTC && s_q.key == 16'h0013 && !psm_clear
    |=> s_q.rtc == ($past(req.wdata[15:0]) & 16'hB3FF))
    else $error("unlocked timekeeping write not stored");

  // read data returned after the wait state carries raw comparator levels
  a_sig_readback_raw: assert property (
    req.rd && req.idx == SKTO_IDX_SIG
    |=> hreadyout && ((hrdata[15:0] & 16'h0C8F) == ($past(ana_raw.sig) & 16'h0C8F)))
    else $error("signal override readback not raw");

  a_chg_readback_raw: assert property (
    req.rd && req.idx == SKTO_IDX_CHG
    |=> (hrdata[15:0] & 16'hC807) == ($past(ana_raw.chg) & 16'hC807))
    else $error("charger override readback not raw");

  // forcing feeds the stored value, otherwise the comparator
  a_force_feed_sel: assert property (
    s_q.force_en |=> deb_in.sig == ($past(s_q.sig) & 16'h0C8F)
                     && deb_in.chg == ($past(s_q.chg) & 16'hC807))
    else $error("forced debounce feed wrong");

  a_normal_feed_sel: assert property (
    !s_q.force_en |=> deb_in.rail == ($past(ana_raw.rail) & 16'h8F3F))
    else $error("unforced debounce feed wrong");

  a_lock_force_high: assert property (s_q.sig[9] |=> loop_lock)
    else $error("loop lock not forced");

  a_lock_follow_raw: assert property (!s_q.sig[9] |=> loop_lock == $past(loop_lock_raw))
    else $error("loop lock does not follow source");

  a_tick_force_sel: assert property (
    s_q.sig[8] |=> deb_tick == $past(fast_tick))
    else $error("debounce tick not replaced");

  a_alarm_force_high: assert property (s_q.sig[6] ##1 s_q.sig[6] |-> alarm)
    else $error("alarm not forced high");

  a_rail_psm_clear: assert property (psm_clear |=> s_q.rail == 16'h0000)
    else $error("rail status not cleared by state machine");

  // key writes land whole, whatever value is written
  a_key_write_store: assert property (
    req.wr && req.idx == SKTO_IDX_KEY && !psm_clear |=> s_q.key == $past(req.wdata[15:0]))
    else $error("key write not stored");

  // the pins of the locked fields must not move either
  a_locked_rtc_pins: assert property (
    req.wr && req.idx == SKTO_IDX_RTC && !unlocked && !psm_clear
    |=> $stable({rtc_tick_ena, rtc_clksrc, osc_ena, rtc_trim}))
    else $error("protected pins changed while locked");

  // state machine clear leaves tick and oscillator enabled, trim zero
  a_rtc_psm_clear: assert property (
    psm_clear |=> {rtc_tick_ena, rtc_clksrc, osc_ena, rtc_trim} == 13'h1400)
    else $error("timekeeping fields not cleared by state machine");

  // timekeeping readback shows the stored fields and the tick status mirror
  a_rtc_readback: assert property (
    req.rd && req.idx == SKTO_IDX_RTC
    |=> hrdata[15:0] == ($past(s_q.rtc) | {1'b0, $past(s_q.rtc[15]), 14'h0000}))
    else $error("timekeeping readback wrong");

  a_rail_readback_raw: assert property (
    req.rd && req.idx == SKTO_IDX_RAIL |=> hrdata[15:0] == ($past(ana_raw.rail) & 16'h8F3F))
    else $error("rail status readback not raw");

  // upper half of every read is zero and a read costs exactly one wait state
  a_read_upper_zero: assert property (req.rd |=> hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  a_read_one_wait: assert property (req.rd |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  // force bits read back what software stored, not a raw level
  a_sig_readback_force: assert property (
    req.rd && req.idx == SKTO_IDX_SIG
    |=> (hrdata[15:0] & 16'h0340) == ($past(s_q.sig) & 16'h0340))
    else $error("force bits readback wrong");

  // override writes keep only the bits that exist
  a_sig_write_store: assert property (
    req.wr && req.idx == SKTO_IDX_SIG |=> s_q.sig == ($past(req.wdata[15:0]) & 16'h0FCF))
    else $error("signal override write not stored");

  a_chg_write_store: assert property (
    req.wr && req.idx == SKTO_IDX_CHG |=> s_q.chg == ($past(req.wdata[15:0]) & 16'hC807))
    else $error("charger override write not stored");

  a_rail_force_feed: assert property (
    s_q.force_en |=> deb_in.rail == ($past(s_q.rail) & 16'h8F3F))
    else $error("forced rail feed wrong");

  a_unforced_feed: assert property (
    !s_q.force_en |=> deb_in.sig == ($past(ana_raw.sig) & 16'h0C8F)
                      && deb_in.chg == ($past(ana_raw.chg) & 16'hC807))
    else $error("unforced signal or charger feed wrong");

  // bits with no comparator behind them never reach the debounce logic
  a_feed_mask_clean: assert property (
    (deb_in.sig & 16'hF370) == 16'h0000 && (deb_in.rail & 16'h70C0) == 16'h0000
    && (deb_in.chg & 16'h37F8) == 16'h0000)
    else $error("debounce feed carries unmapped bits");

  a_tick_follow_raw: assert property (
    !s_q.sig[8] |=> deb_tick == $past(deb_tick_raw))
    else $error("debounce tick does not follow source");

  a_alarm_follow_raw: assert property (
    !s_q.sig[6] |=> alarm == $past(alarm_raw))
    else $error("alarm does not follow source");

  // main scenarios
  c_unlocked_write: cover property (req.wr && req.idx == SKTO_IDX_RTC && unlocked);
  c_locked_write: cover property (req.wr && req.idx == SKTO_IDX_RTC && !unlocked);
  c_sig_read: cover property (req.rd && req.idx == SKTO_IDX_SIG ##1 hreadyout);
  c_forced_tick: cover property (s_q.force_en && s_q.sig[8] && fast_tick);
  c_forced_rail_read: cover property (s_q.force_en && req.rd && req.idx == SKTO_IDX_RAIL);

endmodule : skto_regs

/* testbench/test_security_key_and_test_overrides.sv */
`timescale 1ns/1ps
// ==========================================================
// compare macro: counts every compare, reports each mismatch
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end

module test_security_key_and_test_overrides;
  import skto_pkg::*;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = SKTO_HSIZE_WORD;
  logic loop_lock_raw = 1'b0;
  logic alarm_raw = 1'b0;
  logic deb_tick_raw = 1'b0;
  logic psm_clear = 1'b0;
  skto_ana_t ana_raw = '0;
  skto_ana_t deb_in;
  logic hreadyout, hresp, loop_lock, alarm, deb_tick, rtc_tick_ena, rtc_clksrc, osc_ena;
  logic [31:0] hrdata;
  logic [9:0] rtc_trim;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'hb3be;
  int cyc = 0;

  // ==========================================================
  // device under test, tick divider shortened to keep the run brief
  skto_regs #(.FAST_TICK_DIV(8)) dut (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ana_raw(ana_raw),
    .loop_lock_raw(loop_lock_raw), .alarm_raw(alarm_raw), .deb_tick_raw(deb_tick_raw),
    .psm_clear(psm_clear), .deb_in(deb_in), .loop_lock(loop_lock), .alarm(alarm),
    .deb_tick(deb_tick), .rtc_tick_ena(rtc_tick_ena), .rtc_clksrc(rtc_clksrc),
    .osc_ena(osc_ena), .rtc_trim(rtc_trim)
  );

  // clock and hang guard
  initial begin
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // one single AHB-Lite word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask : settle

  task automatic chk_rtc(input logic [15:0] v);
    `CHK("rtc_fields", {v[15], v[13], v[12], v[9:0]},
         {rtc_tick_ena, rtc_clksrc, osc_ena, rtc_trim})
  endtask : chk_rtc

  // count forwarded ticks over 80 cycles while the normal source pulses every 5th
  task automatic tick_count(input int ex);
    int c, cnt;
    cnt = 0;
    for (c = 0; c < 80; c++) begin
      @(posedge mclk);
      cnt += (deb_tick === 1'b1);
      deb_tick_raw <= (c % 5 == 0);
    end
    `CHK("tick_count", ex, cnt)
  endtask : tick_count

  // debounce feed is the chosen source seen through each register's comparator mask
  function automatic skto_ana_t exp_deb(input skto_ana_t v);
    return {v.sig & SKTO_SIG_CMP, v.rail & SKTO_RAIL_CMP, v.chg & SKTO_CHG_CMP};
  endfunction : exp_deb

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] rd, w;
    skto_ana_t raw;
    int k;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b0, SKTO_IDX_KEY, 32'h0, rd);
    `CHK("key_reset", 32'h0, rd)
    chk_rtc(SKTO_RTC_RST);
    // locked writes with a zero key and an off-by-one key
    for (k = 0; k < 2; k++) begin
      w = $random(seed);
      bus(1'b1, SKTO_IDX_RTC, w, rd);
      settle();
      chk_rtc(SKTO_RTC_RST);
      bus(1'b1, SKTO_IDX_KEY, 32'h0012, rd);
    end
    bus(1'b1, SKTO_IDX_KEY, 32'h0013, rd);
    bus(1'b0, SKTO_IDX_KEY, 32'h0, rd);
    `CHK("key_read", 32'h0013, rd)
    w = $random(seed);
    bus(1'b1, SKTO_IDX_RTC, w, rd);
    settle();
    chk_rtc(w[15:0]);
    bus(1'b0, SKTO_IDX_RTC, 32'h0, rd);
    `CHK("rtc_read", {16'h0, w[15], w[15], w[13:12], 2'h0, w[9:0]}, rd)
    // supply status force, then the state machine clear wipes it and relocks
    bus(1'b1, SKTO_IDX_FEN, 32'h1, rd);
    bus(1'b1, SKTO_IDX_RAIL, 32'hFFFF, rd);
    settle();
    `CHK("rail_forced", SKTO_RAIL_CMP, deb_in.rail)
    @(posedge mclk) psm_clear <= 1'b1;
    @(posedge mclk) psm_clear <= 1'b0;
    settle();
    `CHK("rail_cleared", 16'h0, deb_in.rail)
    chk_rtc(SKTO_RTC_RST);
    bus(1'b1, SKTO_IDX_RTC, ~w, rd);
    settle();
    chk_rtc(SKTO_RTC_RST);
    // random raw levels and force values, force enable toggling each pass
    for (k = 0; k < 8; k++) begin
      raw = 48'({$random(seed), $random(seed)});
      w = $random(seed);
      @(posedge mclk);
      ana_raw <= raw;
      loop_lock_raw <= raw.rail[12];
      alarm_raw <= raw.rail[13];
      bus(1'b1, SKTO_IDX_SIG, {16'h0, w[15:0]}, rd);
      bus(1'b1, SKTO_IDX_CHG, {16'h0, w[31:16]}, rd);
      bus(1'b1, SKTO_IDX_FEN, {31'h0, k[0]}, rd);
      bus(1'b0, SKTO_IDX_FEN, 32'h0, rd);
      `CHK("force_read", {31'h0, k[0]}, rd)
      bus(1'b0, SKTO_IDX_SIG, 32'h0, rd);
      `CHK("sig_read", {16'h0, (raw.sig & SKTO_SIG_CMP) | (w[15:0] & 16'h0340)}, rd)
      bus(1'b0, SKTO_IDX_RAIL, 32'h0, rd);
      `CHK("rail_read", {16'h0, raw.rail & SKTO_RAIL_CMP}, rd)
      bus(1'b0, SKTO_IDX_CHG, 32'h0, rd);
      `CHK("chg_read", {16'h0, raw.chg & SKTO_CHG_CMP}, rd)
      settle();
      `CHK("deb_in", exp_deb(k[0] ? {w[15:0], 16'h0, w[31:16]} : raw), deb_in)
      `CHK("loop_lock", w[9] | raw.rail[12], loop_lock)
      `CHK("alarm", w[6] | raw.rail[13], alarm)
    end
    // forced tick must ignore the normal source entirely
    bus(1'b1, SKTO_IDX_SIG, 32'h0100, rd);
    settle();
    tick_count(10);
    bus(1'b1, SKTO_IDX_SIG, 32'h0, rd);
    settle();
    tick_count(16);
    // unmapped place: write ignored, read gives zero
    bus(1'b1, SKTO_IDX_NONE, 32'hFFFF, rd);
    bus(1'b0, SKTO_IDX_NONE, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    print_verdict();
  end

endmodule : test_security_key_and_test_overrides
